// ==== verilog/clkfo_cfg_slave.sv ====
// config slave of the ten-output clock fan-out: two-wire slave plus register bank
// assumes a master without clock stretching and a glitch-free bus
//
// How it works
// - answer address 11010 plus two strap bits
// - straps pick one of four addresses
// - address bit zero: 0 write, 1 read
// - slave only, fast mode up to 400k
// - command top bit 1, low bits offset
// - word access uses byte n then n+1
// - byte write: addr, command, data, stop
// - upper group phase code, byte 1, reset 0
// - lower group phase code, byte 3, reset 0
// - upper divider off disables outputs 9..5
// - lower divider off disables outputs 4..0
// - upper divide code, byte 2, reset 0
// - lower divide code, byte 4, reset 0
// - chip enable low forces quiescent state
// - byte 5 bits 5..1 enable outputs 9..5
// - master keeps the lines glitch-free
// - divide code maps to eleven ratios
// - phase lead uses only allowed low bits; for multiples of five the code shifts down one first, dropping bit 0
// - outputs 4..0 enabled by bytes 5, 6
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module clkfo_cfg_slave #(
	parameter logic [7:0] MAKER_ID = 8'h5a // arbitrary value
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       bus_id_strap_high_i,
	input  wire logic       bus_id_strap_low_i,
	clkfo_link_if.dev       link,
	output logic            chip_on_o,
	output logic            phase_select_on_o,
	output logic [6:0]      upper_post_divider_o,
	output logic [6:0]      lower_post_divider_o,
	output logic [5:0]      upper_phase_steps_o,
	output logic [5:0]      lower_phase_steps_o,
	output logic [4:0]      upper_phase_lead_o,
	output logic [4:0]      lower_phase_lead_o,
	output logic [9:0]      output_driver_on_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		clkfo_pkg::clkfo_dev_state_e st;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic       scl_p;
		logic       sda_p;
		logic       rw;
		logic [6:0] ptr;
		logic [7:0] up_phase;
		logic [7:0] up_div;
		logic [7:0] lo_phase;
		logic [7:0] lo_div;
		logic [7:0] enables;
		logic [7:0] lo_enable;
		logic       sda_oe;
		logic       chip_on;
		logic       ph_on;
		logic [6:0] up_ratio;
		logic [6:0] lo_ratio;
		logic [5:0] up_steps;
		logic [5:0] lo_steps;
		logic [4:0] up_lead;
		logic [4:0] lo_lead;
		logic [9:0] drv_on;
	} clkfo_dev_s;

	clkfo_dev_s q;
	clkfo_dev_s d;
	logic       scl_s;
	logic       sda_s;
	logic       strap_hi_s;
	logic       strap_lo_s;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	clkfo_sync3 #(.RST_VAL(1'b1)) u_scl (
		.clk_i (clk_i), .rst_i (rst_i), .d_i (link.scl), .q_o (scl_s));
	clkfo_sync3 #(.RST_VAL(1'b1)) u_sda (
		.clk_i (clk_i), .rst_i (rst_i), .d_i (link.sda), .q_o (sda_s));
	clkfo_sync3 #(.RST_VAL(1'b0)) u_sth (
		.clk_i (clk_i), .rst_i (rst_i), .d_i (bus_id_strap_high_i), .q_o (strap_hi_s));
	clkfo_sync3 #(.RST_VAL(1'b0)) u_stl (
		.clk_i (clk_i), .rst_i (rst_i), .d_i (bus_id_strap_low_i), .q_o (strap_lo_s));

	// ------------------------------------------------------------
	// register read mux; byte 7 and above read as zero
	// ------------------------------------------------------------
	function automatic logic [7:0] rd_byte(input clkfo_dev_s s);
		unique case (s.ptr)
			clkfo_pkg::OFS_ID:        rd_byte = MAKER_ID;
			clkfo_pkg::OFS_UP_PHASE:  rd_byte = s.up_phase;
			clkfo_pkg::OFS_UP_DIV:    rd_byte = s.up_div;
			clkfo_pkg::OFS_LO_PHASE:  rd_byte = s.lo_phase;
			clkfo_pkg::OFS_LO_DIV:    rd_byte = s.lo_div;
			clkfo_pkg::OFS_ENABLES:   rd_byte = s.enables;
			clkfo_pkg::OFS_LO_ENABLE: rd_byte = s.lo_enable;
			default:                  rd_byte = 8'h00;
		endcase
	endfunction

	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;

	always_comb begin
		d       = q;
		d.scl_p = scl_s;
		d.sda_p = sda_s;
		start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
		stop_c  = scl_s && q.scl_p && !q.sda_p && sda_s;
		rise_c  = scl_s && !q.scl_p;
		fall_c  = !scl_s && q.scl_p;

		// ------------------------------------------------------------
		// bus engine
		// ------------------------------------------------------------
		if (start_c) begin
			// a repeated start keeps the pointer, so a read follows the command
			d.st     = clkfo_pkg::D_ADDR;
			d.cnt    = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop_c) begin
			d.st     = clkfo_pkg::D_IDLE;
			d.sda_oe = 1'b0;
		end else if (rise_c) begin
			unique case (q.st)
				clkfo_pkg::D_ADDR, clkfo_pkg::D_CMD, clkfo_pkg::D_WDATA: begin
					d.sh  = {q.sh[6:0], sda_s};
					d.cnt = q.cnt + 4'h1;
				end
				clkfo_pkg::D_RDATA_ACK: begin
					if (sda_s) begin
						d.st = clkfo_pkg::D_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (fall_c) begin
			unique case (q.st)
				clkfo_pkg::D_ADDR: begin
					if (q.cnt == 4'h8) begin
						if (q.sh[7:1] == {clkfo_pkg::ADDR_PREFIX, strap_hi_s, strap_lo_s}) begin
							d.st     = clkfo_pkg::D_ADDR_ACK;
							d.rw     = q.sh[0];
							d.sda_oe = 1'b1;
						end else begin
							d.st = clkfo_pkg::D_IDLE;
						end
					end
				end
				clkfo_pkg::D_ADDR_ACK: begin
					d.cnt = 4'h0;
					if (q.rw) begin
						d.st     = clkfo_pkg::D_RDATA;
						d.sh     = rd_byte(q);
						d.sda_oe = !d.sh[7];
					end else begin
						d.st     = clkfo_pkg::D_CMD;
						d.sda_oe = 1'b0;
					end
				end
				clkfo_pkg::D_CMD: begin
					if (q.cnt == 4'h8) begin
						// commands without the select bit are refused with a nack
						if (q.sh[clkfo_pkg::CMD_SEL_BIT]) begin
							d.st     = clkfo_pkg::D_CMD_ACK;
							d.ptr    = q.sh[6:0];
							d.sda_oe = 1'b1;
						end else begin
							d.st = clkfo_pkg::D_IDLE;
						end
					end
				end
				clkfo_pkg::D_CMD_ACK, clkfo_pkg::D_WDATA_ACK: begin
					d.st     = clkfo_pkg::D_WDATA;
					d.cnt    = 4'h0;
					d.sda_oe = 1'b0;
				end
				clkfo_pkg::D_WDATA: begin
					if (q.cnt == 4'h8) begin
						d.st     = clkfo_pkg::D_WDATA_ACK;
						d.sda_oe = 1'b1;
						d.ptr    = q.ptr + 7'h01;
						unique case (q.ptr)
							clkfo_pkg::OFS_UP_PHASE:  d.up_phase = q.sh;
							clkfo_pkg::OFS_UP_DIV:    d.up_div = q.sh;
							clkfo_pkg::OFS_LO_PHASE:  d.lo_phase = q.sh;
							clkfo_pkg::OFS_LO_DIV:    d.lo_div = q.sh;
							clkfo_pkg::OFS_ENABLES:   d.enables = q.sh | 8'h40;
							clkfo_pkg::OFS_LO_ENABLE: d.lo_enable = q.sh;
							default: begin
							end
						endcase
					end
				end
				clkfo_pkg::D_RDATA: begin
					if (q.cnt == 4'h7) begin
						d.st     = clkfo_pkg::D_RDATA_ACK;
						d.sda_oe = 1'b0;
						d.ptr    = q.ptr + 7'h01;
					end else begin
						d.cnt    = q.cnt + 4'h1;
						d.sh     = {q.sh[6:0], 1'b0};
						d.sda_oe = !q.sh[6];
					end
				end
				clkfo_pkg::D_RDATA_ACK: begin
					// master acked: send the next byte
					d.st     = clkfo_pkg::D_RDATA;
					d.cnt    = 4'h0;
					d.sh     = rd_byte(q);
					d.sda_oe = !d.sh[7];
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// decoded outputs
		// ------------------------------------------------------------
		d.chip_on  = q.enables[clkfo_pkg::CHIP_ON_BIT];
		d.ph_on    = q.up_phase[clkfo_pkg::PH_ON_BIT];
		d.up_ratio = clkfo_pkg::ratio_of(q.up_div[3:0]);
		d.lo_ratio = clkfo_pkg::ratio_of(q.lo_div[3:0]);
		d.up_steps = clkfo_pkg::steps_of(q.up_div[3:0]);
		d.lo_steps = clkfo_pkg::steps_of(q.lo_div[3:0]);
		d.up_lead  = d.ph_on ? clkfo_pkg::lead_of(q.up_div[3:0], q.up_phase[4:0]) : 5'h00;
		d.lo_lead  = d.ph_on ? clkfo_pkg::lead_of(q.lo_div[3:0], q.lo_phase[4:0]) : 5'h00;
		d.drv_on[9:5] = q.enables[5:1] & {5{q.up_div[clkfo_pkg::DIV_ON_BIT]}};
		d.drv_on[4:0] = {q.enables[0], q.lo_enable[7:4]} &
			{5{q.lo_div[clkfo_pkg::DIV_ON_BIT]}};
		if (!d.chip_on) begin
			d.drv_on = 10'h000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// every field at its default before the bus engine can run
			q           <= '0;
			q.st        <= clkfo_pkg::D_IDLE;
			q.scl_p     <= 1'b1;
			q.sda_p     <= 1'b1;
			q.up_phase  <= clkfo_pkg::RST_UP_PHASE;
			q.up_div    <= clkfo_pkg::RST_UP_DIV;
			q.lo_phase  <= clkfo_pkg::RST_LO_PHASE;
			q.lo_div    <= clkfo_pkg::RST_LO_DIV;
			q.enables   <= clkfo_pkg::RST_ENABLES;
			q.lo_enable <= clkfo_pkg::RST_LO_ENABLE;
		end else begin
			q <= d;
		end
	end

	assign link.dev_sda_o       = 1'b0;
	assign link.dev_sda_oe      = q.sda_oe;
	assign chip_on_o            = q.chip_on;
	assign phase_select_on_o    = q.ph_on;
	assign upper_post_divider_o = q.up_ratio;
	assign lower_post_divider_o = q.lo_ratio;
	assign upper_phase_steps_o  = q.up_steps;
	assign lower_phase_steps_o  = q.lo_steps;
	assign upper_phase_lead_o   = q.up_lead;
	assign lower_phase_lead_o   = q.lo_lead;
	assign output_driver_on_o   = q.drv_on;
endmodule

// ==== verilog/clkfo_pkg.sv ====
// constants, types and helpers shared by both ends of the clock fan-out config link
// assumes a 100 MHz system clock on both ends
package clkfo_pkg;

	// ------------------------------------------------------------
	// slave address and command byte
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_PREFIX  = 5'h1a;
	localparam int         CMD_SEL_BIT  = 7;

	// ------------------------------------------------------------
	// register byte offsets and values after reset
	// ------------------------------------------------------------
	localparam logic [6:0] OFS_ID        = 7'h00;
	localparam logic [6:0] OFS_UP_PHASE  = 7'h01;
	localparam logic [6:0] OFS_UP_DIV    = 7'h02;
	localparam logic [6:0] OFS_LO_PHASE  = 7'h03;
	localparam logic [6:0] OFS_LO_DIV    = 7'h04;
	localparam logic [6:0] OFS_ENABLES   = 7'h05;
	localparam logic [6:0] OFS_LO_ENABLE = 7'h06;
	localparam logic [7:0] RST_UP_PHASE  = 8'h20;
	localparam logic [7:0] RST_UP_DIV    = 8'h30;
	localparam logic [7:0] RST_LO_PHASE  = 8'h00;
	localparam logic [7:0] RST_LO_DIV    = 8'h30;
	localparam logic [7:0] RST_ENABLES   = 8'hff;
	localparam logic [7:0] RST_LO_ENABLE = 8'hf0;
	localparam int         PH_ON_BIT     = 5;
	localparam int         DIV_ON_BIT    = 5;
	localparam int         CHIP_ON_BIT   = 7;

	// ------------------------------------------------------------
	// bus timing of the master end
	// ------------------------------------------------------------
	localparam int         CLK_NS      = 10;
	localparam int         SCL_LOW_NS  = 1300;
	localparam int         SCL_HIGH_NS = 1200;
	localparam logic [7:0] LOW_CYC     = 8'((SCL_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] HIGH_CYC    = 8'((SCL_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] SDA_SET_CYC = 8'(SCL_LOW_NS / CLK_NS / 2);

	// ------------------------------------------------------------
	// wishbone map of the master end
	// ------------------------------------------------------------
	localparam logic [3:0] WB_CMD    = 4'h0;
	localparam logic [3:0] WB_WDATA  = 4'h4;
	localparam logic [3:0] WB_STATUS = 4'h8;
	localparam logic [3:0] WB_RDATA  = 4'hc;
	localparam int         CMD_RD_BIT   = 8;
	localparam int         CMD_WORD_BIT = 9;

	typedef enum logic [3:0] {
		D_IDLE  = 4'h0, D_ADDR  = 4'h1, D_ADDR_ACK = 4'h2, D_CMD   = 4'h3,
		D_CMD_ACK = 4'h4, D_WDATA = 4'h5, D_WDATA_ACK = 4'h6,
		D_RDATA = 4'h7, D_RDATA_ACK = 4'h8
	} clkfo_dev_state_e;

	typedef enum logic [1:0] {
		H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h2, H_STOP = 2'h3
	} clkfo_host_state_e;

	typedef enum logic [1:0] {
		K_START = 2'h0, K_TX = 2'h1, K_RX = 2'h2, K_STOP = 2'h3
	} clkfo_sym_e;

	// divide ratio for a 4-bit code; unused codes fall back to ratio 1
	function automatic logic [6:0] ratio_of(input logic [3:0] code);
		unique case (code)
			4'h0:    ratio_of = 7'h01;
			4'h1:    ratio_of = 7'h02;
			4'h2:    ratio_of = 7'h04;
			4'h3:    ratio_of = 7'h05;
			4'h4:    ratio_of = 7'h08;
			4'h5:    ratio_of = 7'h0a;
			4'h6:    ratio_of = 7'h10;
			4'h7:    ratio_of = 7'h14;
			4'h8:    ratio_of = 7'h20;
			4'h9:    ratio_of = 7'h28;
			4'ha:    ratio_of = 7'h50;
			default: ratio_of = 7'h01;
		endcase
	endfunction

	// phase steps per period: ratio, or ratio/5 for multiples of five
	function automatic logic [5:0] steps_of(input logic [3:0] code);
		unique case (code)
			4'h1:    steps_of = 6'h02;
			4'h2:    steps_of = 6'h04;
			4'h4:    steps_of = 6'h08;
			4'h5:    steps_of = 6'h02;
			4'h6:    steps_of = 6'h10;
			4'h7:    steps_of = 6'h04;
			4'h8:    steps_of = 6'h20;
			4'h9:    steps_of = 6'h08;
			4'ha:    steps_of = 6'h10;
			default: steps_of = 6'h01;
		endcase
	endfunction

	function automatic logic is_mult5(input logic [3:0] code);
		is_mult5 = (code == 4'h3) || (code == 4'h5) || (code == 4'h7) ||
			(code == 4'h9) || (code == 4'ha);
	endfunction

	// lead in steps: the low bits that the step count allows count, taken after a shift down by one for multiples of five
	function automatic logic [4:0] lead_of(input logic [3:0] code, input logic [4:0] ph);
		logic [4:0] mask;
		mask = 5'(steps_of(code) - 6'h01);
		lead_of = is_mult5(code) ? ((ph >> 1) & mask) : (ph & mask);
	endfunction

endpackage

// ==== verilog/clkfo_link_if.sv ====
// two-wire link between the configuration master and the fan-out config slave
// open-drain lines: a line is low whenever any party enables its driver
`timescale 1ns/1ps
interface clkfo_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// pull-up wins unless a driver pulls low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);
endinterface

// ==== verilog/clkfo_sync3.sv ====
// three-stage input synchroniser: output moves once stages two and three agree
// assumes d_i is asynchronous to clk_i
`timescale 1ns/1ps
module clkfo_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} clkfo_sync_s;

	clkfo_sync_s st_q;
	clkfo_sync_s st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = d_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.q = st_q.s3;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
		end else begin
			st_q <= st_d;
		end
	end

	assign q_o = st_q.q;
endmodule

// ==== verilog/clkfo_cfg_master.sv ====
// two-wire master that runs byte and word register accesses on the config slave
// assumes software on classic wishbone; the slave never stretches the clock
`timescale 1ns/1ps
module clkfo_cfg_master (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	clkfo_link_if.host       link
);
	typedef struct packed {
		clkfo_pkg::clkfo_host_state_e st;
		logic [1:0]  ph;
		logic [7:0]  tmr;
		logic [3:0]  seq;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic        rd;
		logic        word;
		logic [1:0]  strap;
		logic [6:0]  ofs;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        nack;
		logic        busy;
		logic        scl_oe;
		logic        sda_oe;
		logic        ack;
		logic [31:0] dat;
	} clkfo_host_s;

	clkfo_host_s q;
	clkfo_host_s d;
	logic        sda_s;
	logic        adv;
	logic [3:0]  nseq;
	clkfo_pkg::clkfo_sym_e kq;
	clkfo_pkg::clkfo_sym_e kn;

	clkfo_sync3 #(.RST_VAL(1'b1)) u_sda (
		.clk_i (clk_i), .rst_i (rst_i), .d_i (link.sda), .q_o (sda_s));

	// ------------------------------------------------------------
	// transfer script: write S A C D0 [D1] P, read S A C S A R0 [R1] P
	// ------------------------------------------------------------
	function automatic clkfo_pkg::clkfo_sym_e kind(input logic [3:0] s, input clkfo_host_s h);
		if (s == 4'h0 || (h.rd && s == 4'h3)) begin
			kind = clkfo_pkg::K_START;
		end else if (s <= 4'h3 || (h.rd && s == 4'h4) || (!h.rd && s == 4'h4 && h.word)) begin
			kind = clkfo_pkg::K_TX;
		end else if (h.rd && (s == 4'h5 || (s == 4'h6 && h.word))) begin
			kind = clkfo_pkg::K_RX;
		end else begin
			kind = clkfo_pkg::K_STOP;
		end
	endfunction

	function automatic logic [7:0] tx_byte(input logic [3:0] s, input clkfo_host_s h);
		if (s == 4'h1) begin
			tx_byte = {clkfo_pkg::ADDR_PREFIX, h.strap, 1'b0};
		end else if (s == 4'h2) begin
			tx_byte = {1'b1, h.ofs};
		end else if (h.rd) begin
			tx_byte = {clkfo_pkg::ADDR_PREFIX, h.strap, 1'b1};
		end else begin
			tx_byte = (s == 4'h3) ? h.wdata[7:0] : h.wdata[15:8];
		end
	endfunction

	always_comb begin
		d     = q;
		d.ack = 1'b0;
		adv   = 1'b0;
		nseq  = q.seq + 4'h1;
		kq    = kind(q.seq, q);
		kn    = kind(nseq, q);

		// ------------------------------------------------------------
		// wishbone slave: one wait state, unmapped reads zero
		// ------------------------------------------------------------
		if (wb_cyc_i && wb_stb_i && !q.ack) begin
			d.ack = 1'b1;
			d.dat = 32'h0000_0000;
			if (wb_we_i) begin
				if (wb_adr_i == clkfo_pkg::WB_WDATA) begin
					if (wb_sel_i[0]) d.wdata[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) d.wdata[15:8] = wb_dat_i[15:8];
				end else if (wb_adr_i == clkfo_pkg::WB_CMD && wb_sel_i[1:0] == 2'b11 &&
					q.st == clkfo_pkg::H_IDLE) begin
					d.ofs    = wb_dat_i[6:0];
					d.rd     = wb_dat_i[clkfo_pkg::CMD_RD_BIT];
					d.word   = wb_dat_i[clkfo_pkg::CMD_WORD_BIT];
					d.strap  = wb_dat_i[13:12];
					d.st     = clkfo_pkg::H_START;
					d.ph     = 2'h0;
					d.tmr    = clkfo_pkg::LOW_CYC;
					d.seq    = 4'h0;
					d.busy   = 1'b1;
					d.nack   = 1'b0;
					d.scl_oe = 1'b1;
				end
			end else if (wb_adr_i == clkfo_pkg::WB_STATUS) begin
				d.dat[1:0] = {q.nack, q.busy};
			end else if (wb_adr_i == clkfo_pkg::WB_RDATA) begin
				d.dat[15:0] = q.rdata;
			end else if (wb_adr_i == clkfo_pkg::WB_WDATA) begin
				d.dat[15:0] = q.wdata;
			end
		end

		// ------------------------------------------------------------
		// bit engine; scl low phase then high phase
		// ------------------------------------------------------------
		if (q.st != clkfo_pkg::H_IDLE && q.tmr != 8'h00) begin
			d.tmr = q.tmr - 8'h01;
			if (q.ph == 2'h0 && q.tmr == clkfo_pkg::SDA_SET_CYC) begin
				unique case (q.st)
					clkfo_pkg::H_START: d.sda_oe = 1'b0;
					clkfo_pkg::H_STOP:  d.sda_oe = 1'b1;
					default: begin
						if (q.bitn[3]) begin
							d.sda_oe = (kq == clkfo_pkg::K_RX) && q.word && q.seq == 4'h5;
						end else begin
							d.sda_oe = (kq == clkfo_pkg::K_TX) && !q.sh[7];
						end
					end
				endcase
			end
		end else if (q.st != clkfo_pkg::H_IDLE) begin
			if (q.ph == 2'h0) begin
				d.ph     = 2'h1;
				d.scl_oe = 1'b0;
				d.tmr    = clkfo_pkg::HIGH_CYC;
			end else if (q.st == clkfo_pkg::H_BIT) begin
				d.scl_oe = 1'b1;
				d.ph     = 2'h0;
				d.tmr    = clkfo_pkg::LOW_CYC;
				d.bitn   = q.bitn + 4'h1;
				if (!q.bitn[3]) begin
					d.sh = {q.sh[6:0], sda_s};
				end else if (kq == clkfo_pkg::K_TX && sda_s) begin
					d.nack = 1'b1;
					d.st   = clkfo_pkg::H_STOP;
				end else begin
					if (kq == clkfo_pkg::K_RX && q.seq == 4'h5) d.rdata[7:0] = q.sh;
					if (kq == clkfo_pkg::K_RX && q.seq == 4'h6) d.rdata[15:8] = q.sh;
					adv = 1'b1;
				end
			end else if (q.ph == 2'h1) begin
				d.ph     = 2'h2;
				d.sda_oe = (q.st == clkfo_pkg::H_START);
				d.tmr    = (q.st == clkfo_pkg::H_START) ? clkfo_pkg::HIGH_CYC : clkfo_pkg::LOW_CYC;
			end else if (q.st == clkfo_pkg::H_START) begin
				d.scl_oe = 1'b1;
				adv      = 1'b1;
			end else begin
				d.st   = clkfo_pkg::H_IDLE;
				d.busy = 1'b0;
			end
		end

		if (adv) begin
			d.seq  = nseq;
			d.ph   = 2'h0;
			d.tmr  = clkfo_pkg::LOW_CYC;
			d.bitn = 4'h0;
			d.sh   = tx_byte(nseq, q);
			unique case (kn)
				clkfo_pkg::K_START: d.st = clkfo_pkg::H_START;
				clkfo_pkg::K_STOP:  d.st = clkfo_pkg::H_STOP;
				default:            d.st = clkfo_pkg::H_BIT;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q    <= '0;
			q.st <= clkfo_pkg::H_IDLE;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o         = q.dat;
	assign wb_ack_o         = q.ack;
	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = q.scl_oe;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = q.sda_oe;
endmodule

// ==== dv/clkfo_link_assertions.sv ====
// checker for the open-drain link between the two config ends
// assumes it sees the resolved lines and every party's driver enable
`timescale 1ns/1ps
module clkfo_link_assertions (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic host_scl_oe,
	input  wire logic host_sda_oe,
	input  wire logic dev_sda_oe,
	input  wire logic scl,
	input  wire logic sda
);
	logic [15:0] low_q;
	logic [15:0] high_q;
	// high count saturates, and starts full after reset since the bus was free
	always_ff @(posedge clk_i) begin
		low_q  <= (rst_i || scl) ? 16'h0000 : low_q + 16'h0001;
		high_q <= (rst_i || !scl) ? {16{rst_i}} : high_q + 16'(high_q != 16'hffff);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_SCL_LOW_MIN: assert property ($rose(scl)
		|-> low_q >= 16'(clkfo_pkg::LOW_CYC))
		else $error("scl low phase too short");
	AST_SCL_HIGH_MIN: assert property ($fell(scl) |-> high_q >= 16'h003c)
		else $error("scl high phase too short");
	AST_DEV_SDA_TIMING: assert property ($changed(dev_sda_oe)
		|-> !scl && !$past(scl, 3))
		else $error("slave moved sda outside scl low");
	AST_DEV_SDA_HOLD: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*8])
		else $error("slave sda drive not held");
	AST_IDLE_AFTER_RST: assert property ($fell(rst_i) |-> scl && sda && !dev_sda_oe)
		else $error("link not idle after reset");
	AST_START_SETUP: assert property ($fell(sda) && scl
		|-> host_sda_oe && high_q >= 16'h003c)
		else $error("bad start condition");
	AST_STOP_OWNER: assert property ($rose(sda) && scl
		|-> !dev_sda_oe && $past(host_sda_oe))
		else $error("stop not made by master");
	AST_SDA_STABLE_HIGH: assert property (scl && $past(scl) && $changed(sda)
		|-> $changed(host_sda_oe))
		else $error("sda moved during scl high");
endmodule

// ==== dv/tb_clkfo_cfg_slave.sv ====
// bench: master end driven over wishbone, slave end on the same link
// assumes package and link interface are compiled first
`timescale 1ns/1ps
module tb_clkfo_cfg_slave;
	logic        clk_i, rst_i, cyc, stb, we, ack, chip_on, ph_on;
	logic [3:0]  adr;
	logic [31:0] dat, rdat, rd;
	logic [1:0]  strap = 2'b10;
	logic [6:0]  up_div, lo_div;
	logic [5:0]  up_st, lo_st;
	logic [4:0]  up_ld, lo_ld;
	logic [9:0]  drv_on;
	int          num_errors = 0, compares = 0, cyc_cnt = 0;

	clkfo_link_if link ();
	clkfo_cfg_master i_clkfo_cfg_master (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
	// maker code value is arbitrary
	clkfo_cfg_slave #(.MAKER_ID(8'h3c)) i_clkfo_cfg_slave (.clk_i(clk_i), .rst_i(rst_i),
		.bus_id_strap_high_i(strap[1]), .bus_id_strap_low_i(strap[0]), .link(link),
		.chip_on_o(chip_on), .phase_select_on_o(ph_on), .upper_post_divider_o(up_div),
		.lower_post_divider_o(lo_div), .upper_phase_steps_o(up_st),
		.lower_phase_steps_o(lo_st), .upper_phase_lead_o(up_ld),
		.lower_phase_lead_o(lo_ld), .output_driver_on_o(drv_on));
	clkfo_link_assertions i_clkfo_link_assertions (.clk_i(clk_i), .rst_i(rst_i),
		.host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic cycle; the timeout below bounds the wait for ack
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		{cyc, stb} <= 2'b00;
	endtask

	// command bits: [13:12] strap, [9] word, [8] read, [6:0] offset
	task automatic op(input logic [13:0] c, input logic [15:0] d, input logic nack);
		wb(1'b1, clkfo_pkg::WB_WDATA, 32'(d));
		wb(1'b1, clkfo_pkg::WB_CMD, 32'(c));
		do wb(1'b0, clkfo_pkg::WB_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
		chk(32'(rd[1]), 32'(nack));
		wb(1'b0, clkfo_pkg::WB_RDATA, 32'h0000_0000);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 90000) begin
			num_errors++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, dat} = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(32'({chip_on, ph_on, drv_on, up_div, lo_ld}), 32'h00ff_f020);
		op(14'h1101, 16'h0000, 1'b1);
		op(14'h2201, 16'h2a3f, 1'b0);
		chk(32'({up_div, up_st, up_ld, ph_on}), 32'h0005_041f);
		op(14'h2004, 16'h0007, 1'b0);
		chk(32'({lo_div, lo_st, drv_on[4:0]}), 32'h0000_a080);
		op(14'h2003, 16'h0007, 1'b0);
		chk(32'(lo_ld), 32'h0000_0003);
		op(14'h2005, 16'h003c, 1'b0);
		chk(32'({chip_on, drv_on}), 32'h0000_0000);
		op(14'h2005, 16'h00bc, 1'b0);
		chk(32'({chip_on, drv_on[9:5]}), 32'h0000_003e);
		op(14'h2000, 16'h00ff, 1'b0);
		op(14'h2301, 16'h0000, 1'b0);
		chk(32'(rd[15:0]), 32'h0000_2a3f);
		op(14'h2100, 16'h0000, 1'b0);
		chk(32'(rd[7:0]), 32'h0000_003c);
		wb(1'b0, 4'h2, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		complete_run();
	end
endmodule
